// ---- an_params.svh ----
// Register map, field positions, reset values and timing constants.
`ifndef AN_PARAMS_SVH
`define AN_PARAMS_SVH

// Register indices on the management port.
`define AN_REG_CTL      5'h00
`define AN_REG_STS      5'h01
`define AN_REG_ADV      5'h04
`define AN_REG_LPA      5'h05
`define AN_REG_EXP      5'h06
`define AN_REG_NPT      5'h07
`define AN_REG_GIG      5'h09

// Basic mode control fields.
`define AN_CTL_SPD_LSB  13
`define AN_CTL_NEGOTIATION_ENABLE_STRAP    12
`define AN_CTL_RESTART  9
`define AN_CTL_DUPLEX   8
`define AN_CTL_SPD_MSB  6

// Basic mode status: fixed ability bits and live fields.
`define AN_STS_FIXED    16'h7909
`define AN_STS_DONE     5
`define AN_STS_RFLT     4
`define AN_STS_LINK     2

// Advertisement and partner ability fields.
`define AN_ADV_NP       15
`define AN_ADV_RFLT     13
`define AN_ADV_ASYM     11
`define AN_ADV_PAUSE    10
`define AN_ADV_100FD    8
`define AN_ADV_100HD    7
`define AN_ADV_10FD     6
`define AN_ADV_10HD     5
`define AN_SEL_W        5
`define AN_SEL_8023     5'h01
`define AN_ADV_BASE     16'h0C01

// Expansion fields.
`define AN_EXP_PDF      4
`define AN_EXP_LPNP     3
`define AN_EXP_NPA      2
`define AN_EXP_PR       1
`define AN_EXP_LPAN     0

// Next page transmit reset value and gigabit control fields.
`define AN_NPT_RST      16'h2001
`define AN_GIG_FD       9
`define AN_GIG_HD       8

// Resolved speed codes as reported in the control register.
`define AN_SPD_10       2'h0
`define AN_SPD_100      2'h1
`define AN_SPD_1000     2'h2

// Break link timer.
`define AN_BREAK_MS     1500
`define AN_CLK_KHZ      40000
`define AN_BRK_W        26

`endif

// ---- an_pkg.sv ----
// Types shared by the negotiation register logic.
package an_pkg;

  typedef enum logic [3:0]
  {
    AN_ST_FORCED = 4'h1,
    AN_ST_BREAK  = 4'h2,
    AN_ST_NEGO   = 4'h4,
    AN_ST_LINKED = 4'h8
  } an_state_e;

  typedef struct packed
  {
    logic        negotiation_enable_strap;
    logic        spd_high;
    logic        spd_low;
    logic        duplex;
  } an_strap_s;

  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } an_mgmt_req_s;

  typedef struct packed
  {
    logic        page_valid;
    logic [15:0] page_word;
    logic        arb_done;
    logic        gig_fd;
    logic        gig_hd;
    logic        pd_link10;
    logic        pd_link100;
    logic        link_good;
    logic        np_taken;
  } an_link_in_s;

  typedef struct packed
  {
    logic        flp_enable;
    logic        complete;
    logic [1:0]  speed;
    logic        full_duplex;
    logic [15:0] base_page;
    logic [15:0] gig_page;
    logic        np_valid;
    logic [15:0] next_page;
  } an_link_out_s;

endpackage : an_pkg

// ---- an_break_timer.sv ----
// Break link timer: one pulse a fixed number of cycles after start.
`include "an_params.svh"

module an_break_timer
#(
  parameter int unsigned CYCLES = 16
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  output logic      expired
);

  localparam logic [`AN_BRK_W-1:0] LOAD = `AN_BRK_W'(CYCLES - 1);

  logic [`AN_BRK_W-1:0] cnt;
  logic                 running;

  assign expired = running && (cnt == '0);

  always_ff @(posedge clk)
  begin
    if (!rst_n || start)
      cnt <= LOAD;
    else if (running && cnt != '0)
      cnt <= cnt - 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      running <= 1'b0;
    else if (start)
      running <= 1'b1;
    else if (expired)
      running <= 1'b0;
  end

endmodule : an_break_timer

// ---- an_regs.sv ----
// Negotiation control, advertisement and result registers of the PHY.
`include "an_params.svh"

// What this block does
// R1: Advertise pause and asymmetric pause from advertisement bits 10 and 11.
// R2: Store partner pause and asymmetric pause in partner ability bits 10, 11.
// R3: Never resolve pause mode; only advertise and report pause abilities.
// R4: The MAC reads partner ability after negotiation and picks pause mode.
// R5: Next page transmit register holds the next page word sent out.
// R6: Parallel detect completion sets partner bit 5 or 7 and selector 00001.
// R7: Parallel detect completion reads expansion bit 0 as zero.
// R8: In parallel detect mode, any non-good link sets expansion bit 4.
// R9: Losing a negotiated link resumes negotiation automatically.
// R10: Writing one to control bit 9 after completion restarts negotiation.
// R11: Restart silences pulses for the 1500 ms break timer, then sends bursts.
// R12: Software clears then sets control bit 12 to leave forced mode.
// R13: Strapped negotiation, speed and duplex settings are overridable by writes.
// R14: With negotiation on, transmit advertisement and gigabit control abilities.
// R15: Speed straps pick advertised speeds; duplex strap picks half or full.
// R16: Resolve to the highest common mode including gigabit abilities.
// R17: Status shows complete bit 5, remote fault bit 4, link bit 2.
// R18: Status ability, negotiation ability and extended bits are always set.
// R19: Advertisement defaults to strap-picked speeds plus pause bits; writes replace them.
// R20: Partner ability holds the base page, overwritten by each next page.
// R21: Without next pages the base page stays held after completion.
// R22: Software saves each page, checks bit 15, writes further next pages.
// R23: Expansion reports partner NP, local NP, page received, partner able.
// R24: Page received flag clears on read; each new page sets it again.
module an_regs
  import an_pkg::*;
#(
  parameter int unsigned BREAK_CYCLES = `AN_BREAK_MS * `AN_CLK_KHZ
)
(
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           rst_n,
  // Strap pins
  input  an_pkg::an_strap_s    strap,
  // Station management port
  input  an_pkg::an_mgmt_req_s mgmt,
  output logic [15:0]          rdata,
  // Link pulse engine
  input  an_pkg::an_link_in_s  lnk_in,
  output an_pkg::an_link_out_s lnk_out
);

  import an_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage and decode.

  an_state_e   state;
  an_state_e   next_state;
  logic        ctl_negotiation_enable_strap;
  logic [1:0]  ctl_spd;
  logic        ctl_dup;
  logic [15:0] adv;
  logic [15:0] gig;
  logic [15:0] npt;
  logic [15:0] lpa;
  logic [15:0] base_q;
  logic        np_pending;
  logic        page_seen;
  logic        exp_pr;
  logic        exp_pdf;
  logic        exp_lpnp;
  logic        exp_lpan;
  logic        pd_mode;
  logic [1:0]  res_spd;
  logic        res_dup;
  logic        wr_ctl;
  logic        wr_adv;
  logic        wr_npt;
  logic        wr_gig;
  logic        rd_exp;
  logic        restart_req;
  logic        pd_hit;
  logic        arb_hit;
  logic        brk_start;
  logic        brk_expired;
  logic        relink;
  logic [1:0]  next_spd;
  logic        next_dup;
  logic [15:0] pd_word;
  logic [15:0] cmp_word;

  assign wr_ctl = mgmt.wr && (mgmt.addr == `AN_REG_CTL);
  assign wr_adv = mgmt.wr && (mgmt.addr == `AN_REG_ADV);
  assign wr_npt = mgmt.wr && (mgmt.addr == `AN_REG_NPT);
  assign wr_gig = mgmt.wr && (mgmt.addr == `AN_REG_GIG);
  assign rd_exp = mgmt.rd && (mgmt.addr == `AN_REG_EXP);

  // Restart is honoured whenever negotiation is on, in any state.
  assign restart_req = wr_ctl && mgmt.wdata[`AN_CTL_RESTART]
                       && ctl_negotiation_enable_strap; // see R10

  ////////////////////////////////////////////////////////////////////////////
  // Control register, strapped at reset and writable at any time.

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctl_negotiation_enable_strap <= strap.negotiation_enable_strap;
      ctl_spd   <= {strap.spd_high, strap.spd_low};
      ctl_dup   <= strap.duplex;
    end
    else if (wr_ctl)
    begin
      ctl_negotiation_enable_strap <= mgmt.wdata[`AN_CTL_NEGOTIATION_ENABLE_STRAP]; // see R13
      ctl_spd   <= {mgmt.wdata[`AN_CTL_SPD_MSB], mgmt.wdata[`AN_CTL_SPD_LSB]};
      ctl_dup   <= mgmt.wdata[`AN_CTL_DUPLEX];
    end
  end

  // Advertised speeds follow the speed straps; duplex strap picks HD or FD.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      adv <= `AN_ADV_BASE; // see R19
      adv[`AN_ADV_10HD]  <= !strap.duplex
                            && (strap.spd_low == strap.spd_high); // see R15
      adv[`AN_ADV_10FD]  <= strap.duplex
                            && (strap.spd_low == strap.spd_high);
      adv[`AN_ADV_100HD] <= !strap.duplex && !strap.spd_high;
      adv[`AN_ADV_100FD] <= strap.duplex && !strap.spd_high;
    end
    else if (wr_adv)
      adv <= mgmt.wdata; // see R1
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gig <= '0;
      gig[`AN_GIG_FD] <= strap.duplex; // see R15
      gig[`AN_GIG_HD] <= !strap.duplex;
    end
    else if (wr_gig)
      gig <= mgmt.wdata; // see R13
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      npt <= `AN_NPT_RST;
    else if (wr_npt)
      npt <= mgmt.wdata; // see R5
  end

  // A fresh next page stays pending until the engine takes it; set wins.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      np_pending <= 1'b0;
    else if (wr_npt)
      np_pending <= 1'b1;
    else if (lnk_in.np_taken)
      np_pending <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Negotiation sequencing.

  assign arb_hit = (state == AN_ST_NEGO) && lnk_in.arb_done;
  assign pd_hit  = (state == AN_ST_NEGO) && !lnk_in.arb_done && !page_seen
                   && (lnk_in.pd_link10 || lnk_in.pd_link100);

  always_comb
  begin
    next_state = state;
    case (state)
      AN_ST_FORCED:
        if (ctl_negotiation_enable_strap)
          next_state = AN_ST_BREAK;
      AN_ST_BREAK:
        if (brk_expired)
          next_state = AN_ST_NEGO; // see R11
      AN_ST_NEGO:
        if (arb_hit || pd_hit)
          next_state = AN_ST_LINKED;
      AN_ST_LINKED:
        if (!lnk_in.link_good)
          next_state = AN_ST_NEGO; // see R9
      default:
        next_state = AN_ST_FORCED;
    endcase
    if (!ctl_negotiation_enable_strap)
      next_state = AN_ST_FORCED;
    else if (restart_req)
      next_state = AN_ST_BREAK; // see R10
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state <= AN_ST_FORCED;
    else
      state <= next_state;
  end

  assign brk_start = (next_state == AN_ST_BREAK)
                     && ((state != AN_ST_BREAK) || restart_req);

  // A lost link renegotiates from scratch, so the old base page is dropped.
  assign relink = (state == AN_ST_LINKED)
                  && (next_state == AN_ST_NEGO); // see R9

  an_break_timer #(
    .CYCLES (BREAK_CYCLES)
  ) u_break (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (brk_start),
    .expired (brk_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Partner pages and expansion flags.

  always_comb
  begin
    pd_word = '0;
    pd_word[`AN_SEL_W-1:0] = `AN_SEL_8023; // see R6
    pd_word[`AN_ADV_100HD] = lnk_in.pd_link100;
    pd_word[`AN_ADV_10HD]  = !lnk_in.pd_link100;
  end

  // Each received page overwrites the previous one; pause bits ride along.
  always_ff @(posedge clk)
  begin
    if (!rst_n || brk_start)
      lpa <= '0;
    else if (pd_hit)
      lpa <= pd_word; // see R6
    else if (state == AN_ST_NEGO && lnk_in.page_valid)
      lpa <= lnk_in.page_word; // see R2, R20, R21
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || brk_start || relink)
    begin
      page_seen <= 1'b0;
      base_q    <= '0;
      exp_lpnp  <= 1'b0;
      exp_lpan  <= 1'b0;
    end
    else if (state == AN_ST_NEGO && lnk_in.page_valid && !page_seen)
    begin
      page_seen <= 1'b1;
      base_q    <= lnk_in.page_word;
      exp_lpnp  <= lnk_in.page_word[`AN_ADV_NP]; // see R23
      exp_lpan  <= 1'b1; // see R7
    end
  end

  // Page received: a page in the read cycle sets it again.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      exp_pr <= 1'b0;
    else if (state == AN_ST_NEGO && lnk_in.page_valid)
      exp_pr <= 1'b1; // see R23
    else if (rd_exp)
      exp_pr <= 1'b0; // see R24
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || brk_start || arb_hit)
      pd_mode <= 1'b0;
    else if (pd_hit)
      pd_mode <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      exp_pdf <= 1'b0;
    else if (pd_mode && !lnk_in.link_good)
      exp_pdf <= 1'b1; // see R8
    else if (rd_exp)
      exp_pdf <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Highest common mode; pause is left for the MAC to resolve.

  assign cmp_word = pd_hit ? pd_word : base_q;

  always_comb
  begin
    next_spd = `AN_SPD_10;
    next_dup = 1'b0;
    if (!pd_hit && gig[`AN_GIG_FD] && lnk_in.gig_fd)
    begin
      next_spd = `AN_SPD_1000; // see R16
      next_dup = 1'b1;
    end
    else if (!pd_hit && gig[`AN_GIG_HD] && lnk_in.gig_hd)
      next_spd = `AN_SPD_1000;
    else if (adv[`AN_ADV_100FD] && cmp_word[`AN_ADV_100FD])
    begin
      next_spd = `AN_SPD_100;
      next_dup = 1'b1;
    end
    else if (cmp_word[`AN_ADV_100HD] && (adv[`AN_ADV_100HD] || pd_hit))
      next_spd = `AN_SPD_100;
    else if (adv[`AN_ADV_10FD] && cmp_word[`AN_ADV_10FD])
      next_dup = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      res_spd <= `AN_SPD_10;
      res_dup <= 1'b0;
    end
    else if (arb_hit || pd_hit)
    begin
      res_spd <= next_spd;
      res_dup <= next_dup;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link engine outputs and register reads.

  always_comb
  begin
    lnk_out             = '0;
    lnk_out.flp_enable  = (state == AN_ST_NEGO); // see R11, R14
    lnk_out.complete    = (state == AN_ST_LINKED);
    lnk_out.speed       = ctl_negotiation_enable_strap ? res_spd : ctl_spd;
    lnk_out.full_duplex = ctl_negotiation_enable_strap ? res_dup : ctl_dup;
    lnk_out.base_page   = adv; // see R1, R3, R14
    lnk_out.gig_page    = gig;
    lnk_out.np_valid    = np_pending;
    lnk_out.next_page   = npt; // see R5
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata <= '0;
    else if (mgmt.rd)
    begin
      rdata <= '0;
      case (mgmt.addr)
        `AN_REG_CTL:
        begin
          rdata[`AN_CTL_NEGOTIATION_ENABLE_STRAP]   <= ctl_negotiation_enable_strap;
          rdata[`AN_CTL_SPD_MSB] <= lnk_out.speed[1]; // see R17
          rdata[`AN_CTL_SPD_LSB] <= lnk_out.speed[0];
          rdata[`AN_CTL_DUPLEX]  <= lnk_out.full_duplex;
        end
        `AN_REG_STS:
        begin
          rdata <= `AN_STS_FIXED; // see R18
          rdata[`AN_STS_DONE] <= (state == AN_ST_LINKED); // see R17
          rdata[`AN_STS_RFLT] <= lpa[`AN_ADV_RFLT] && !pd_mode;
          rdata[`AN_STS_LINK] <= (state == AN_ST_LINKED)
                                 && lnk_in.link_good;
        end
        `AN_REG_ADV: rdata <= adv;
        `AN_REG_LPA: rdata <= lpa; // see R2
        `AN_REG_EXP:
        begin
          rdata[`AN_EXP_PDF]  <= exp_pdf;
          rdata[`AN_EXP_LPNP] <= exp_lpnp;
          rdata[`AN_EXP_NPA]  <= 1'b1;
          rdata[`AN_EXP_PR]   <= exp_pr;
          rdata[`AN_EXP_LPAN] <= exp_lpan && !pd_mode; // see R7
        end
        `AN_REG_NPT: rdata <= npt;
        `AN_REG_GIG: rdata <= gig;
        default:     rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_restart_written;
    wr_ctl && mgmt.wdata[`AN_CTL_RESTART] && ctl_negotiation_enable_strap;
  endsequence

  sequence s_pd_complete;
    pd_hit;
  endsequence

  a_restart_break: assert property // see R10
    (s_restart_written |=> state == AN_ST_BREAK)
    else $error("restart write did not enter break");

  a_break_quiet: assert property // see R11
    (state == AN_ST_BREAK |-> !lnk_out.flp_enable)
    else $error("pulses sent during break");

  a_break_exit: assert property // see R11
    (state == AN_ST_BREAK && brk_expired && ctl_negotiation_enable_strap && !restart_req
     |=> lnk_out.flp_enable)
    else $error("bursts did not resume after break");

  a_pd_selector: assert property // see R6
    (s_pd_complete |=> lpa[`AN_SEL_W-1:0] == `AN_SEL_8023
     && (lpa[`AN_ADV_100HD] != lpa[`AN_ADV_10HD]))
    else $error("parallel detect did not load partner word");

  a_pd_not_able: assert property // see R7
    (pd_mode && mgmt.rd && mgmt.addr == `AN_REG_EXP
     |=> !rdata[`AN_EXP_LPAN])
    else $error("partner able shown after parallel detect");

  a_pd_fault: assert property // see R8
    (pd_mode && !lnk_in.link_good |=> exp_pdf)
    else $error("parallel detect fault not flagged");

  a_link_resume: assert property // see R9
    (state == AN_ST_LINKED && !lnk_in.link_good && ctl_negotiation_enable_strap
     && !restart_req |=> state == AN_ST_NEGO ##0 lnk_out.flp_enable)
    else $error("lost link did not resume negotiation");

  a_page_flag: assert property // see R24
    (state == AN_ST_NEGO && lnk_in.page_valid |=> exp_pr
     && lpa == $past(lnk_in.page_word))
    else $error("received page not stored or flagged");

  a_pause_adv: assert property // see R1
    (wr_adv |=> lnk_out.base_page[`AN_ADV_ASYM:`AN_ADV_PAUSE]
     == $past(mgmt.wdata[`AN_ADV_ASYM:`AN_ADV_PAUSE]))
    else $error("pause advertisement not taken");

  a_status_fixed: assert property // see R18
    (mgmt.rd && mgmt.addr == `AN_REG_STS
     |=> (rdata & `AN_STS_FIXED) == `AN_STS_FIXED)
    else $error("fixed status bits missing");

endmodule : an_regs

// ---- an_partner_model.sv ----
// Behavioural far-side link engine: page exchange or parallel detect.
module an_partner_model
(
  // Clock
  input  wire logic            clk,
  // Commands from the bench
  input  wire logic            go,
  input  wire logic            use_np,
  input  wire logic [15:0]     base_word,
  input  wire logic [15:0]     np_word,
  input  wire logic            gig_full,
  input  wire logic [1:0]      pd_sel,
  input  wire logic            link_up,
  // Register block side
  input  an_pkg::an_link_out_s lnk_out,
  output an_pkg::an_link_in_s  lnk_in
);
  import an_pkg::*;

  logic        pv;
  logic        ad;
  logic        nt;
  logic [15:0] pw;
  int          n;

  assign lnk_in = '{pv, pw, ad, gig_full, 1'b0, pd_sel[0], pd_sel[1],
                    link_up, nt};

  ////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [15:0] w, input logic take);
    pw = w;
    pv = 1'b1;
    nt = take;
    @(negedge clk);
    {pv, nt} = 2'b00;
    pw = ~w;
  endtask : send

  // Between pages the word toggles so a stale word is never taken for new.
  initial
  begin
    {pv, ad, nt} = 3'b000;
    pw = 16'h0000;
    forever
    begin
      @(negedge clk);
      pw = ~pw;
      if (go && lnk_out.flp_enable)
      begin
        repeat (3) @(negedge clk);
        send(base_word, 1'b0);
        if (use_np)
        begin
          for (n = 0; n < 200 && !lnk_out.np_valid; n++)
            @(negedge clk);
          // A slow answer leaves the pending page visible for a while.
          repeat (4) @(negedge clk);
          send(np_word, 1'b1);
        end
        ad = 1'b1;
        @(negedge clk);
        ad = 1'b0;
        wait (!go);
      end
    end
  end
endmodule : an_partner_model

// ---- test_an_regs.sv ----
// Self-checking bench for the negotiation register block.
`include "an_params.svh"

module test_an_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import an_pkg::*;

  localparam int BRK = 16;

  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  an_strap_s    strap = '0;
  an_mgmt_req_s mgmt = '0;
  logic [15:0]  rdata;
  an_link_in_s  lnk_in;
  an_link_out_s lnk_out;
  logic         go = 1'b0;
  logic         use_np = 1'b0;
  logic [15:0]  base_word = 16'h0000;
  logic [15:0]  np_word = 16'h0000;
  logic         gig_full = 1'b0;
  logic [1:0]   pd_sel = 2'b00;
  logic         link_up = 1'b0;
  logic [15:0]  rv;
  logic [15:0]  adv;
  int           miscompares = 0;
  int           cmp_count = 0;
  int           waited;

  always #12.5 clk = ~clk;

  an_regs #(.BREAK_CYCLES(BRK)) i_dut
  (
    .clk(clk), .rst_n(rst_n), .strap(strap), .mgmt(mgmt),
    .rdata(rdata), .lnk_in(lnk_in), .lnk_out(lnk_out)
  );

  an_partner_model i_far
  (
    .clk(clk), .go(go), .use_np(use_np), .base_word(base_word),
    .np_word(np_word), .gig_full(gig_full), .pd_sel(pd_sel),
    .link_up(link_up), .lnk_out(lnk_out), .lnk_in(lnk_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgmt = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    mgmt = '0;
    @(negedge clk);
  endtask : wr

  task automatic rck(input logic [4:0] a, input logic [15:0] m,
                     input logic [15:0] e);
    mgmt = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk);
    mgmt = '0;
    @(negedge clk);
    rv = rdata;
    chk(rv & m, e);
  endtask : rck

  task automatic reset_dut(input logic en, input logic h, input logic l,
                           input logic d);
    rst_n = 1'b0;
    strap = '{en, h, l, d};
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
  endtask : reset_dut

  function automatic logic probe(input int what);
    case (what)
      0: return lnk_in.page_valid;
      1: return lnk_out.flp_enable;
      default: return lnk_out.complete;
    endcase
  endfunction : probe

  task automatic wait_for(input int what, input int lim);
    waited = 0;
    do
    begin
      @(posedge clk);
      waited++;
    end
    while (probe(what) !== 1'b1 && waited < lim);
    chk(16'(waited < lim), 16'h0001);
    @(negedge clk);
  endtask : wait_for

  task automatic wait_break;
    wait_for(1, BRK + 20);
    chk(16'(waited >= BRK && waited <= BRK + 3), 16'h0001);
  endtask : wait_break

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      reset_dut(1'b0, i[2], i[1], i[0]);
      adv = `AN_ADV_BASE;
      if (i[2] == i[1])
        adv |= i[0] ? 16'h0040 : 16'h0020;
      if (!i[2])
        adv |= i[0] ? 16'h0100 : 16'h0080;
      chk(lnk_out.base_page, adv);
      chk(lnk_out.gig_page, i[0] ? 16'h0200 : 16'h0100);
      rck(`AN_REG_ADV, 16'hFFFF, adv);
      if (i[2:1] != 2'b11)
        chk(lnk_out.speed, i[2:1]);
      chk(lnk_out.full_duplex, i[0]);
    end
    done("straps");
    reset_dut(1'b1, 1'b0, 1'b0, 1'b1);
    rck(`AN_REG_STS, 16'hFFFF, `AN_STS_FIXED);
    rck(`AN_REG_EXP, 16'hFFFF, 16'h0004);
    rck(`AN_REG_NPT, 16'hFFFF, `AN_NPT_RST);
    wr(`AN_REG_STS, 16'h0000);
    wr(5'h02, 16'hFFFF);
    rck(`AN_REG_STS, 16'hFFFF, `AN_STS_FIXED);
    rck(5'h02, 16'hFFFF, 16'h0000);
    wr(`AN_REG_ADV, 16'h0141);
    chk(lnk_out.base_page, 16'h0141);
    wr(`AN_REG_ADV, 16'h0D41);
    chk(lnk_out.base_page, 16'h0D41);
    rck(`AN_REG_ADV, 16'hFFFF, 16'h0D41);
    wr(`AN_REG_GIG, 16'h0300);
    chk(lnk_out.gig_page, 16'h0300);
    done("registers");
    wait_for(1, 2 * BRK);
    {base_word, np_word, use_np, gig_full, link_up} =
      {16'h8D41, 16'h0123, 3'b111};
    go = 1'b1;
    wait_for(0, 20);
    rck(`AN_REG_LPA, 16'hFFFF, 16'h8D41);
    rck(`AN_REG_EXP, 16'hFFFF, 16'h000F);
    rck(`AN_REG_EXP, 16'hFFFF, 16'h000D);
    wr(`AN_REG_NPT, 16'h0ABC);
    chk(lnk_out.next_page, 16'h0ABC);
    chk(lnk_out.np_valid, 1'b1);
    wait_for(2, 40);
    rck(`AN_REG_LPA, 16'hFFFF, 16'h0123);
    chk(lnk_out.np_valid, 1'b0);
    chk(lnk_out.speed, `AN_SPD_1000);
    chk(lnk_out.full_duplex, 1'b1);
    rck(`AN_REG_STS, 16'hFFFF, 16'h792D);
    rck(`AN_REG_CTL, 16'h3340, 16'h1140);
    go = 1'b0;
    done("next pages");
    link_up = 1'b0;
    repeat (2) @(negedge clk);
    chk(lnk_out.flp_enable, 1'b1);
    chk(lnk_out.complete, 1'b0);
    {base_word, use_np, gig_full, link_up} = {16'h2141, 3'b001};
    go = 1'b1;
    wait_for(2, 40);
    go = 1'b0;
    chk(lnk_out.speed, `AN_SPD_100);
    rck(`AN_REG_LPA, 16'hFFFF, 16'h2141);
    rck(`AN_REG_EXP, 16'hFFFF, 16'h0007);
    rck(`AN_REG_STS, 16'h0034, 16'h0034);
    done("relink");
    for (int i = 0; i < 2; i++)
    begin
      wr(`AN_REG_CTL, 16'h1200);
      wait_break;
      rck(`AN_REG_LPA, 16'hFFFF, 16'h0000);
      pd_sel = i ? 2'b01 : 2'b10;
      wait_for(2, 20);
      rck(`AN_REG_LPA, 16'hFFFF, i ? 16'h0021 : 16'h0081);
      rck(`AN_REG_EXP, 16'h0001, 16'h0000);
      rck(`AN_REG_STS, 16'h0020, 16'h0020);
      chk(lnk_out.speed, i ? `AN_SPD_10 : `AN_SPD_100);
      link_up = 1'b0;
      @(negedge clk);
      link_up = 1'b1;
      wait_for(2, 20);
      rck(`AN_REG_EXP, 16'h0010, 16'h0010);
      rck(`AN_REG_EXP, 16'h0010, 16'h0000);
      pd_sel = 2'b00;
    end
    done("restart");
    wr(`AN_REG_CTL, 16'h0140);
    chk(lnk_out.flp_enable, 1'b0);
    chk(lnk_out.complete, 1'b0);
    chk(lnk_out.speed, `AN_SPD_1000);
    rck(`AN_REG_CTL, 16'h3340, 16'h0140);
    wr(`AN_REG_CTL, 16'h1000);
    wait_break;
    done("forced");
    complete_run;
  end

  // The whole sequence needs well under a thousand cycles.
  initial
  begin
    #100us;
    miscompares++;
    complete_run;
  end
endmodule : test_an_regs
